// ===== hw/csc_pkg.sv
// Operation
// - Enable bit 7 low keeps the unit off; high makes it ready.
// - Done flag bit 5 sets on each result; only software clears it.
// - Busy bit 4 reads 1 only while a conversion runs.
// - Busy write 1 starts only in modes 000, 110, 111; 0 does nothing.
// - Comparator enable bit 3 gates the greater-than comparison.
// - Read-only bit 0 shows result above threshold at last compare.
// - Modes 001..100 start on timer 0, 2, 1, 3 overflow; 101 reserved.
// - Mode 000 starts one conversion per busy write of 1.
// - Mode 110 converts one channel continuously after busy write of 1.
// - Mode 111 scans continuously after busy write of 1.
// - Field bits 1:0 picks 1, 4, 8 or 16 samples per result.
// - Result bytes hold the last result and change only on completion.
// - Unused control and config bits read zero, writes ignored.
// - Summed samples divided by count, 16-bit quotient to result.
// - Flag and comparison happen only after the set's last sample.
// - Scan steps channel on each result except one that halts scanning; wraps from last to first.
// - Greater-than during scan halts scanning until busy write of 1.
package csc_pkg;
   localparam logic [7:0] OFF_CONTROL   = 8'h9A;
   localparam logic [7:0] OFF_CONFIG    = 8'h9E;
   localparam logic [7:0] OFF_RES_LOW   = 8'hA9;
   localparam logic [7:0] OFF_RES_HIGH  = 8'hAA;
   localparam logic [7:0] RESET_VALUE   = 8'h00;

   localparam int B_ENABLE   = 7;
   localparam int B_DONE     = 5;
   localparam int B_BUSY     = 4;
   localparam int B_CMP_EN   = 3;
   localparam int B_CMP_FLAG = 0;
   localparam int F_MODE_LO  = 4;
   localparam int F_MODE_HI  = 6;
   localparam int F_ACU_LO   = 0;
   localparam int F_ACU_HI   = 1;

   localparam logic [2:0] M_SW   = 3'h0;
   localparam logic [2:0] M_T0   = 3'h1;
   localparam logic [2:0] M_T2   = 3'h2;
   localparam logic [2:0] M_T1   = 3'h3;
   localparam logic [2:0] M_T3   = 3'h4;
   localparam logic [2:0] M_CONT = 3'h6;
   localparam logic [2:0] M_SCAN = 3'h7;

   localparam logic [1:0] ACU_1  = 2'h0;
   localparam logic [1:0] ACU_4  = 2'h1;
   localparam logic [1:0] ACU_8  = 2'h2;
   localparam logic [1:0] ACU_16 = 2'h3;
   localparam logic [3:0] CNT_1  = 4'h0;
   localparam logic [3:0] CNT_4  = 4'h3;
   localparam logic [3:0] CNT_8  = 4'h7;
   localparam logic [3:0] CNT_16 = 4'hF;
   localparam int SH_1  = 0;
   localparam int SH_4  = 2;
   localparam int SH_8  = 3;
   localparam int SH_16 = 4;

   localparam int SAMPLE_W = 16;
   localparam int SUM_W    = 20;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } csc_sfr_req_t;

   typedef enum logic [0:0] {
      S_IDLE = 1'b0,
      S_CONV = 1'b1
   } csc_state_t;
endpackage

// ===== hw/csc_accum.sv
`timescale 1ns/1ps
module csc_accum
   import csc_pkg::*;
#(
   parameter int SW = SAMPLE_W,
   parameter int AW = SUM_W
) (
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire logic          clear,
   input  wire logic          add,
   input  wire logic [SW-1:0] sample,
   input  wire logic [1:0]    acu_sel,
   output logic               last,
   output logic [SW-1:0]      quot
);
   generate
      if (AW < SW + 4) begin : g_bad_width
         $error("csc_accum: sum too narrow for 16 samples");
      end
   endgenerate

   logic [AW-1:0] sum_q;
   logic [AW-1:0] sum_d;
   logic [3:0]    cnt_q;
   logic [3:0]    target;
   logic [AW-1:0] shifted;

   assign sum_d = sum_q + AW'(sample);

   always_comb begin
      case (acu_sel)
         ACU_1:   target = CNT_1;
         ACU_4:   target = CNT_4;
         ACU_8:   target = CNT_8;
         ACU_16:  target = CNT_16;
         default: target = CNT_1;
      endcase
   end

   assign last = (cnt_q == target);

   always_comb begin
      case (acu_sel)
         ACU_1:   shifted = sum_d >> SH_1;
         ACU_4:   shifted = sum_d >> SH_4;
         ACU_8:   shifted = sum_d >> SH_8;
         ACU_16:  shifted = sum_d >> SH_16;
         default: shifted = sum_d;
      endcase
   end
   assign quot = shifted[SW-1:0];

   always_ff @(posedge sys_clk) begin
      if (!reset_n || clear) begin
         sum_q <= '0;
         cnt_q <= 4'h0;
      end else if (add) begin
         sum_q <= sum_d;
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// ===== hw/csc_ctrl.sv
`timescale 1ns/1ps
module csc_ctrl
   import csc_pkg::*;
#(
   parameter int CH_W = 5
) (
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   input  wire csc_sfr_req_t       sfr_req,
   output logic [7:0]              sfr_rdata_q,
   input  wire logic [3:0]         timer_ovf,
   input  wire logic [15:0]        threshold,
   input  wire logic [CH_W-1:0]    scan_first_channel,
   input  wire logic [CH_W-1:0]    scan_last_channel,
   input  wire logic               chan_wr,
   input  wire logic [CH_W-1:0]    chan_wdata,
   input  wire logic               afe_done,
   input  wire logic [15:0]        afe_sample,
   output logic                    unit_enable_q,
   output logic                    afe_start_q,
   output logic                    conv_done_flag_q,
   output logic                    cmp_greater_flag_q,
   output logic [CH_W-1:0]         channel_select_q
);
   generate
      if (CH_W < 1 || CH_W > 8) begin : g_bad_ch
         $error("csc_ctrl: channel width out of range");
      end
   endgenerate

   csc_state_t     state_q;
   logic           cmp_enable_q;
   logic [2:0]     start_mode_select_q;
   logic [1:0]     accum_count_select_q;
   logic           run_q;
   logic           scan_hold_q;
   logic [15:0]    result_q;
   logic           wr_ctl;
   logic           wr_cfg;
   logic           busy_wr1;
   logic           sw_mode;
   logic           cont_mode;
   logic           tmr_hit;
   logic           start_req;
   logic           conv_busy;
   logic           acc_last;
   logic [15:0]    quot;
   logic           load;
   logic           greater;
   logic           advance;

   assign wr_ctl    = sfr_req.wr && (sfr_req.addr == OFF_CONTROL);
   assign wr_cfg    = sfr_req.wr && (sfr_req.addr == OFF_CONFIG);
   assign busy_wr1  = wr_ctl && sfr_req.wdata[B_BUSY];
   assign conv_busy = (state_q == S_CONV);
   assign cont_mode = (start_mode_select_q == M_CONT) ||
                      (start_mode_select_q == M_SCAN);
   assign sw_mode   = (start_mode_select_q == M_SW) || cont_mode;

   // timer source map; overflows are pulses
   always_comb begin
      case (start_mode_select_q)
         M_T0:    tmr_hit = timer_ovf[0];
         M_T2:    tmr_hit = timer_ovf[2];
         M_T1:    tmr_hit = timer_ovf[1];
         M_T3:    tmr_hit = timer_ovf[3];
         default: tmr_hit = 1'b0;
      endcase
   end

   assign start_req = unit_enable_q && !conv_busy &&
                      ((busy_wr1 && sw_mode) || tmr_hit ||
                       (run_q && cont_mode && !scan_hold_q));

   assign load    = conv_busy && afe_done && acc_last && unit_enable_q;
   assign greater = quot > threshold;
   assign advance = load && (start_mode_select_q == M_SCAN) &&
                    !(cmp_enable_q && greater);

   csc_accum #(
      .SW (SAMPLE_W),
      .AW (SUM_W)
   ) u_accum (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .clear   (start_req),
      .add     (conv_busy && afe_done),
      .sample  (afe_sample),
      .acu_sel (accum_count_select_q),
      .last    (acc_last),
      .quot    (quot)
   );

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         unit_enable_q <= 1'b0;
         cmp_enable_q  <= 1'b0;
      end else if (wr_ctl) begin
         unit_enable_q <= sfr_req.wdata[B_ENABLE];
         cmp_enable_q  <= sfr_req.wdata[B_CMP_EN];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         start_mode_select_q  <= 3'h0;
         accum_count_select_q <= 2'h0;
      end else if (wr_cfg) begin
         start_mode_select_q  <= sfr_req.wdata[F_MODE_HI:F_MODE_LO];
         accum_count_select_q <= sfr_req.wdata[F_ACU_HI:F_ACU_LO];
      end
   end

   // conversion sequencer; disable aborts at once
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start_req) begin
                  state_q <= S_CONV;
               end
            end
            S_CONV: begin
               if (!unit_enable_q || load) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         afe_start_q <= 1'b0;
      end else begin
         afe_start_q <= start_req ||
                        (conv_busy && afe_done && !acc_last &&
                         unit_enable_q);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         run_q <= 1'b0;
      end else if (!unit_enable_q || !cont_mode) begin
         run_q <= 1'b0;
      end else if (busy_wr1) begin
         run_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         scan_hold_q <= 1'b0;
      end else if (load && start_mode_select_q == M_SCAN &&
                   cmp_enable_q && greater) begin
         scan_hold_q <= 1'b1;
      end else if (busy_wr1) begin
         scan_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         result_q <= 16'h0000;
      end else if (load) begin
         result_q <= quot;
      end
   end

   // sticky done, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         conv_done_flag_q <= 1'b0;
      end else if (load) begin
         conv_done_flag_q <= 1'b1;
      end else if (wr_ctl) begin
         conv_done_flag_q <= sfr_req.wdata[B_DONE];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cmp_greater_flag_q <= 1'b0;
      end else if (load && cmp_enable_q) begin
         cmp_greater_flag_q <= greater;
      end
   end

   // scan step and wrap; software write wins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         channel_select_q <= '0;
      end else if (chan_wr) begin
         channel_select_q <= chan_wdata;
      end else if (advance) begin
         if (channel_select_q == scan_last_channel) begin
            channel_select_q <= scan_first_channel;
         end else begin
            channel_select_q <= channel_select_q + CH_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !sfr_req.rd) begin
         sfr_rdata_q <= RESET_VALUE;
      end else begin
         case (sfr_req.addr)
            OFF_CONTROL:  sfr_rdata_q <= {unit_enable_q, 1'b0,
                                          conv_done_flag_q, conv_busy,
                                          cmp_enable_q, 2'b00,
                                          cmp_greater_flag_q};
            OFF_CONFIG:   sfr_rdata_q <= {1'b0, start_mode_select_q,
                                          2'b00, accum_count_select_q};
            OFF_RES_LOW:  sfr_rdata_q <= result_q[7:0];
            OFF_RES_HIGH: sfr_rdata_q <= result_q[15:8];
            default:      sfr_rdata_q <= RESET_VALUE;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_disabled_idle;
      !unit_enable_q |=> !conv_busy;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle)
      else $error("busy while disabled");

   property p_done_sticky;
      conv_done_flag_q && !(wr_ctl && !sfr_req.wdata[B_DONE])
         |=> conv_done_flag_q;
   endproperty
   a_done_sticky: assert property (p_done_sticky)
      else $error("done flag lost without software clear");

   property p_busy_start;
      start_req |=> conv_busy ##0 afe_start_q;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start not reflected in busy");

   property p_sw_no_start;
      start_mode_select_q == M_SW && !run_q && !conv_busy && !busy_wr1
         |=> !conv_busy;
   endproperty
   a_sw_no_start: assert property (p_sw_no_start)
      else $error("conversion started without trigger");

   property p_cmp_gate;
      !cmp_enable_q |=> $stable(cmp_greater_flag_q);
   endproperty
   a_cmp_gate: assert property (p_cmp_gate)
      else $error("comparator moved while disabled");

   property p_cmp_value;
      load && cmp_enable_q
         |=> cmp_greater_flag_q == ($past(quot) > $past(threshold));
   endproperty
   a_cmp_value: assert property (p_cmp_value)
      else $error("comparator flag wrong");

   property p_timer_start;
      unit_enable_q && !conv_busy && start_mode_select_q == M_T2 &&
         timer_ovf[2] |=> afe_start_q;
   endproperty
   a_timer_start: assert property (p_timer_start)
      else $error("timer overflow did not start");

   property p_sw_start;
      unit_enable_q && !conv_busy && start_mode_select_q == M_SW &&
         busy_wr1 |=> afe_start_q && conv_busy;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software start missed");

   property p_cont_restart;
      unit_enable_q && run_q && cont_mode && !scan_hold_q && !conv_busy
         |=> afe_start_q;
   endproperty
   a_cont_restart: assert property (p_cont_restart)
      else $error("continuous mode did not restart");

   property p_result_stable;
      !load |=> $stable(result_q);
   endproperty
   a_result_stable: assert property (p_result_stable)
      else $error("result changed without completion");

   property p_wrap;
      advance && !chan_wr && channel_select_q == scan_last_channel
         |=> channel_select_q == $past(scan_first_channel);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("scan did not wrap");

   property p_hold;
      scan_hold_q && !busy_wr1 && start_mode_select_q == M_SCAN
         |-> !start_req ##1 scan_hold_q;
   endproperty
   a_hold: assert property (p_hold)
      else $error("scan resumed while held");

   property p_load_together;
      load |=> !conv_busy && conv_done_flag_q &&
               result_q == $past(quot);
   endproperty
   a_load_together: assert property (p_load_together)
      else $error("result load not aligned with busy and flag");

   c_scan_load: cover property (load && start_mode_select_q == M_SCAN);
   c_hold_set: cover property ($rose(scan_hold_q));
   c_acc16: cover property (load && accum_count_select_q == ACU_16);
   c_timer: cover property (tmr_hit && start_req);
endmodule

// ===== tb/csc_afe_model.sv
`timescale 1ns/1ps
module csc_afe_model (
   input  wire logic        sys_clk,
   input  wire logic        afe_start_q,
   input  wire logic [2:0]  lat,
   input  wire logic [15:0] base,
   input  wire logic        kclr,
   output logic             afe_done,
   output logic [15:0]      afe_sample,
   output int               n_start
);
   logic [15:0] k;
   initial begin
      afe_done = 1'b0;
      afe_sample = 16'h0000;
      k = 16'h0000;
      n_start = 0;
   end
   always @(posedge sys_clk) begin
      if (kclr)
         k <= 16'h0000;
      if (afe_start_q) begin
         n_start <= n_start + 1;
         repeat (lat) @(posedge sys_clk);
         @(negedge sys_clk);
         afe_done <= 1'b1;
         afe_sample <= base + k;
         k <= k + 16'h0001;
         @(negedge sys_clk);
         afe_done <= 1'b0;
         // Stale data inverted, never left looking valid
         afe_sample <= ~afe_sample;
      end
   end
endmodule

// ===== tb/tb_csc_ctrl.sv
`timescale 1ns/1ps
module tb_csc_ctrl
   import csc_pkg::*;
;
   logic         sys_clk;
   logic         reset_n;
   csc_sfr_req_t req;
   logic [7:0]   rdata;
   logic [3:0]   tov;
   logic [15:0]  thr;
   logic [4:0]   sf;
   logic [4:0]   sl;
   logic         cw;
   logic [4:0]   cd;
   logic         adone;
   logic [15:0]  asmp;
   logic         en;
   logic         astart;
   logic         done;
   logic         cmpf;
   logic [4:0]   ch;
   logic [4:0]   c0;
   logic [2:0]   lat;
   logic [15:0]  base;
   logic         kclr;
   logic [15:0]  e;
   logic [15:0]  pe;
   logic         pf;
   logic [7:0]   d;
   logic [1:0]   tm [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
   int           nst;
   int           s0;
   int           n;
   int           i;
   int           cyc;
   int           error_cnt;
   int           n_tests;
   int unsigned  sd;

   csc_ctrl u_csc_ctrl (
      .sys_clk            (sys_clk),
      .reset_n            (reset_n),
      .sfr_req            (req),
      .sfr_rdata_q        (rdata),
      .timer_ovf          (tov),
      .threshold          (thr),
      .scan_first_channel (sf),
      .scan_last_channel  (sl),
      .chan_wr            (cw),
      .chan_wdata         (cd),
      .afe_done           (adone),
      .afe_sample         (asmp),
      .unit_enable_q      (en),
      .afe_start_q        (astart),
      .conv_done_flag_q   (done),
      .cmp_greater_flag_q (cmpf),
      .channel_select_q   (ch)
   );

   csc_afe_model u_csc_afe_model (
      .sys_clk     (sys_clk),
      .afe_start_q (astart),
      .lat         (lat),
      .base        (base),
      .kclr        (kclr),
      .afe_done    (adone),
      .afe_sample  (asmp),
      .n_start     (nst)
   );

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard, run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
      n_tests++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, x, g);
      end
   endtask

   task automatic wreg(logic [7:0] a, logic [7:0] v);
      @(negedge sys_clk);
      req.addr = a;
      req.wdata = v;
      req.wr = 1'b1;
      @(negedge sys_clk);
      req.wr = 1'b0;
   endtask

   task automatic rreg(logic [7:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      req.addr = a;
      req.rd = 1'b1;
      @(negedge sys_clk);
      req.rd = 1'b0;
      v = rdata;
   endtask

   task automatic rc(string nm, logic [7:0] a, logic [7:0] x);
      logic [7:0] v;
      rreg(a, v);
      chk(nm, x, v);
   endtask

   task automatic pulse(logic [3:0] v);
      tov = v;
      @(negedge sys_clk);
      tov = 4'h0;
   endtask

   task automatic wait_done();
      int w;
      w = 0;
      while (done !== 1'b1 && w < 400) begin
         @(negedge sys_clk);
         w++;
      end
      chk("done", 1, done);
   endtask

   function automatic logic [15:0] avg(logic [15:0] b, int k);
      logic [19:0] s;
      s = 20'h00000;
      for (int j = 0; j < k; j++)
         s = s + 20'(b + 16'(j));
      return 16'(s >> $clog2(k));
   endfunction

   initial begin
      sd = $urandom(32'hC4E4065B);
      reset_n = 1'b0;
      req = '0;
      {tov, thr, sf, sl, cw, cd, base, kclr, pe} = '0;
      lat = 3'h3;
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      rc("ctl", OFF_CONTROL, 8'h00);
      rc("cfg", OFF_CONFIG, 8'h00);
      rc("hi", OFF_RES_HIGH, 8'h00);
      rc("nomap", 8'h9B, 8'h00);
      wreg(OFF_CONTROL, 8'hFF);
      rc("ctl", OFF_CONTROL, 8'hA8);
      wreg(OFF_CONFIG, 8'hFF);
      rc("cfg", OFF_CONFIG, 8'h73);
      wreg(OFF_RES_LOW, 8'h5A);
      rc("lo", OFF_RES_LOW, 8'h00);
      wreg(OFF_CONTROL, 8'h80);
      chk("en", 1, en);
      for (int a = 0; a < 4; a++) begin
         n = 1 << ((a == 0) ? 0 : a + 1);
         base = 16'($urandom_range(32'hFFEF));
         lat = 3'($urandom_range(6, 3));
         e = avg(base, n);
         // Gated pass picks a threshold that would flip the old flag
         thr = (a == 0) ? e - 16'h0001 : (a == 1) ? e :
               (a == 2) ? 16'($urandom) : {16{pf}};
         if (a < 3)
            pf = (e > thr);
         kclr = 1'b1;
         @(negedge sys_clk);
         kclr = 1'b0;
         wreg(OFF_CONFIG, 8'(a));
         wreg(OFF_CONTROL, (a == 3) ? 8'h80 : 8'h88);
         s0 = nst;
         wreg(OFF_CONTROL, (a == 3) ? 8'h90 : 8'h98);
         rreg(OFF_CONTROL, d);
         chk("busy", 1, d[4]);
         rc("hold", OFF_RES_LOW, pe[7:0]);
         wait_done();
         chk("nsmp", n, nst - s0);
         rc("lo", OFF_RES_LOW, e[7:0]);
         rc("hi", OFF_RES_HIGH, e[15:8]);
         chk("cmpf", pf, cmpf);
         rreg(OFF_CONTROL, d);
         chk("idle", 0, d[4]);
         repeat (8) @(negedge sys_clk);
         chk("sticky", 1, done);
         wreg(OFF_CONTROL, 8'h80);
         chk("clr", 0, done);
         repeat (3) @(negedge sys_clk);
         chk("once", n, nst - s0);
         pe = e;
      end
      for (int m = 1; m <= 4; m++) begin
         wreg(OFF_CONFIG, 8'(m << 4));
         s0 = nst;
         wreg(OFF_CONTROL, 8'h90);
         pulse(4'hF & ~(4'h1 << tm[m-1]));
         repeat (3) @(negedge sys_clk);
         chk("tmiss", 0, nst - s0);
         pulse(4'h1 << tm[m-1]);
         wait_done();
         chk("thit", 1, nst - s0);
         wreg(OFF_CONTROL, 8'h80);
      end
      wreg(OFF_CONFIG, 8'h50);
      s0 = nst;
      wreg(OFF_CONTROL, 8'h90);
      pulse(4'hF);
      repeat (4) @(negedge sys_clk);
      chk("rsvd", 0, nst - s0);
      wreg(OFF_CONFIG, 8'h60);
      s0 = nst;
      wreg(OFF_CONTROL, 8'h90);
      repeat (60) @(negedge sys_clk);
      chk("cont", 1, (nst - s0) > 3);
      wreg(OFF_CONTROL, 8'h00);
      repeat (10) @(negedge sys_clk);
      s0 = nst;
      wreg(OFF_CONTROL, 8'h10);
      repeat (10) @(negedge sys_clk);
      chk("off", 0, nst - s0);
      chk("en", 0, en);
      sf = 5'h02;
      sl = 5'h04;
      cd = 5'h02;
      cw = 1'b1;
      @(negedge sys_clk);
      cw = 1'b0;
      lat = 3'h2;
      wreg(OFF_CONTROL, 8'h80);
      wreg(OFF_CONFIG, 8'h70);
      wreg(OFF_CONTROL, 8'h90);
      for (int j = 0; j < 6; j++) begin
         i = 0;
         while (adone !== 1'b1 && i < 50) begin
            @(negedge sys_clk);
            i++;
         end
         chk("chan", 2 + (j + 1) % 3, ch);
         @(negedge sys_clk);
      end
      thr = 16'h0000;
      base = 16'h0100;
      wreg(OFF_CONTROL, 8'h88);
      repeat (30) @(negedge sys_clk);
      s0 = nst;
      c0 = ch;
      repeat (30) @(negedge sys_clk);
      chk("halt", s0, nst);
      chk("hold", c0, ch);
      chk("gt", 1, cmpf);
      wreg(OFF_CONTROL, 8'h98);
      repeat (4) @(negedge sys_clk);
      chk("resume", 1, nst > s0);
      end_of_test();
   end
endmodule
